// ===== src/edge_rise.sv
`timescale 1ns/100ps
`default_nettype none
module edge_rise
  import sys_opt_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] level, // Levels to watch.
  output logic [WIDTH-1:0] rise // High in the cycle a level first reads 1.
);

  logic [WIDTH-1:0] prev_d;
  logic [WIDTH-1:0] prev_q;

  // Only a 0 to 1 change counts; a held high level fires once.
  always_comb begin
    prev_d = level;
    rise = level & ~prev_q; // [RL14]
  end

  // Previous levels start low, so a source high at release fires once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rise_only;
    rise != '0 |=> (prev_q & $past(rise)) == $past(rise);
  endproperty
  a_rise_only: assert property (p_rise_only) // [RL14]
    else $error("edge seen without a rising level");

endmodule : edge_rise
`default_nettype wire

// ===== src/sys_opt_pkg.sv
package sys_opt_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_PIN_POWER = 16'h3004;
  localparam logic [15:0] IDX_ROUTING = 16'h3005;
  localparam logic [15:0] IDX_DELAY_STATUS = 16'h3006;
  localparam logic [15:0] IDX_DELAY_MODULO = 16'h3007;
  localparam logic [15:0] ADDR_PIN_POWER = {IDX_PIN_POWER[13:0], 2'b00};
  localparam logic [15:0] ADDR_ROUTING = {IDX_ROUTING[13:0], 2'b00};
  localparam logic [15:0] ADDR_DELAY_STATUS = {IDX_DELAY_STATUS[13:0], 2'b00};
  localparam logic [15:0] ADDR_DELAY_MODULO = {IDX_DELAY_MODULO[13:0], 2'b00};

  // Field positions of the pin and power option register.
  localparam int unsigned BIT_RESET_PIN = 2;
  localparam int unsigned BIT_FAST_WAKE = 1;
  localparam int unsigned BIT_STOP_PERMIT = 0;

  // Field positions of the signal routing option register, and of the delay status active bit.
  localparam int unsigned BIT_TX_MOD = 7;
  localparam int unsigned BIT_PWM_SYNC = 6;
  localparam int unsigned BIT_RX_FILTER = 5;
  localparam int unsigned BIT_RX_CAPTURE = 4;
  localparam int unsigned BIT_CMP_CAPTURE = 3;
  localparam int unsigned BIT_OVF_CAPTURE = 2;
  localparam int unsigned BIT_DELAY_ACTIVE = 7;

  // Values after reset, and the mask of routing bits kept on a write.
  localparam logic [7:0] ROUTING_RESET = 8'h00;
  localparam logic [7:0] MODULO_RESET = 8'h00;
  localparam logic [7:0] ROUTING_STORE_MASK = 8'hBF;

  // Bus clock cycles after a stop in which software raises no interrupt.
  localparam int unsigned FAST_WAKE_GUARD_CYCLES = 8;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    TRIG_RTC = 2'b00,
    TRIG_MODULO = 2'b01,
    TRIG_T2_INIT = 2'b10,
    TRIG_T2_MATCH = 2'b11
  } trig_src_e;

  typedef struct packed {
    logic tx_data;
    logic timer_zero_ch0;
    logic serial_receive_in;
    logic comparator_out;
    logic rtc_overflow;
    logic modulo_overflow;
    logic t2_init_trig;
    logic t2_match_trig;
  } route_in_s;

  typedef struct packed {
    logic serial_transmit_out;
    logic rx_to_receiver;
    logic timer_zero_ch1;
    logic timer_one_ch0;
    logic timer_one_ch1;
    logic pwm_sync_trigger;
    logic converter_trigger;
  } route_out_s;

endpackage : sys_opt_pkg

// ===== src/system_option_routing_regs.sv
// Operation
// [RL1] Fast wake is write-once; set, CPU wakes without servicing an interrupt.
// [RL2] With fast wake, software raises no interrupt 0-8 cycles after stop.
// [RL3] Stop permit is write-once, clears on every reset; 1 allows stop.
// [RL4] Stop while stop is not permitted gives an illegal-opcode reset.
// [RL5] The routing register is read and written freely at any time.
// [RL6] Software writes the routing register during reset initialisation.
// [RL7] Bit 7 set: transmit output is modulated by timer zero channel 0.
// [RL8] Writing 1 to bit 6 sends one PWM sync pulse to timer two.
// [RL9] Bit 5 set: receive input goes through the comparator first.
// [RL10] Bit 4 set: receive input also feeds timer zero channel 1.
// [RL11] Bit 3 set: comparator output goes to timer one channel 0.
// [RL12] Bit 2 set: counter overflow goes to timer one channel 1.
// [RL13] Bits 1-0 pick the converter trigger source among four.
// [RL14] Every converter trigger source acts on its rising edge only.
// [RL15] Reset pin enable set: the shared port pin acts as reset input.
// [RL16] Timer-two triggers pass an 8-bit one-shot delay of 0 to 255.
// [RL17] A write-once control takes the first write after reset only.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module system_option_routing_regs
  import sys_opt_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DELAY_W = 8
) (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous system reset, active low.
  input wire logic por_n, // Synchronous power-on reset, active low.
  input wire logic [ADDR_W-1:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [ADDR_W-1:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire route_in_s route_i, // Peripheral signals to be routed.
  output route_out_s route_o, // Routed peripheral signals.
  input wire logic stop_request, // CPU executes a stop, one cycle.
  output logic enter_stop, // Stop mode entered, one cycle.
  output logic illegal_opcode_reset, // Illegal-opcode reset, one cycle.
  output logic wake_without_isr, // Wake resumes without interrupt service.
  input wire logic port_a_pin_five, // Level on the shared port pin.
  output logic pin_reset_mode, // Shared pin serves as reset input.
  output logic external_reset // Reset requested through the pin.
);

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HAVE_AW = 2'b01,
    WR_HAVE_W = 2'b10,
    WR_RESP = 2'b11
  } wr_state_e;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

  // Address decode shared by the read and the write path.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [15:0] a16;
    a16 = 16'(a);
    addr_hit = (a16 == ADDR_PIN_POWER) || (a16 == ADDR_ROUTING) ||
               (a16 == ADDR_DELAY_STATUS) || (a16 == ADDR_DELAY_MODULO);
  endfunction : addr_hit

  wr_state_e wr_state_d, wr_state_q;
  rd_state_e rd_state_d, rd_state_q;
  logic [ADDR_W-1:0] aw_lat_d, aw_lat_q;
  logic [31:0] w_lat_d, w_lat_q;
  logic [3:0] s_lat_d, s_lat_q;
  logic awready_d, awready_q, wready_d, wready_q;
  logic bvalid_d, bvalid_q, arready_d, arready_q, rvalid_d, rvalid_q;
  logic [1:0] bresp_d, bresp_q, rresp_d, rresp_q;
  logic [31:0] rdata_d, rdata_q;
  logic aw_fire, w_fire, wr_do;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // Write channel: address and data are taken in either order.
  always_comb begin
    aw_fire = awvalid && awready_q;
    w_fire = wvalid && wready_q;
    wr_state_d = wr_state_q;
    aw_lat_d = aw_lat_q;
    w_lat_d = w_lat_q;
    s_lat_d = s_lat_q;
    bresp_d = bresp_q;
    wr_do = 1'b0;
    wr_addr = (wr_state_q == WR_HAVE_AW) ? aw_lat_q : awaddr;
    wr_data = (wr_state_q == WR_HAVE_W) ? w_lat_q : wdata;
    wr_strb = (wr_state_q == WR_HAVE_W) ? s_lat_q : wstrb;
    case (wr_state_q)
      WR_IDLE: begin
        if (aw_fire && w_fire) begin
          wr_do = 1'b1;
        end else if (aw_fire) begin
          aw_lat_d = awaddr;
          wr_state_d = WR_HAVE_AW;
        end else if (w_fire) begin
          w_lat_d = wdata;
          s_lat_d = wstrb;
          wr_state_d = WR_HAVE_W;
        end
      end
      WR_HAVE_AW: wr_do = w_fire;
      WR_HAVE_W: wr_do = aw_fire;
      WR_RESP: begin
        if (bready) begin
          wr_state_d = WR_IDLE;
        end
      end
      default: wr_state_d = WR_IDLE;
    endcase
    if (wr_do) begin
      wr_state_d = WR_RESP;
      bresp_d = addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_d = (wr_state_d == WR_IDLE) || (wr_state_d == WR_HAVE_W);
    wready_d = (wr_state_d == WR_IDLE) || (wr_state_d == WR_HAVE_AW);
    bvalid_d = (wr_state_d == WR_RESP);
  end

  logic fast_wake_d, fast_wake_q, stop_permit_d, stop_permit_q;
  logic reset_pin_d, reset_pin_q, lock_d, lock_q;
  logic [7:0] routing_d, routing_q, modulo_d, modulo_q;
  logic sync_d;
  logic delay_active, delay_done;

  // Register file. The pin and power register locks on its first write.
  always_comb begin
    fast_wake_d = fast_wake_q;
    stop_permit_d = stop_permit_q;
    reset_pin_d = reset_pin_q;
    lock_d = lock_q;
    routing_d = routing_q;
    modulo_d = modulo_q;
    sync_d = 1'b0;
    if (wr_do && wr_strb[0]) begin
      case (16'(wr_addr))
        ADDR_PIN_POWER: begin
          if (!lock_q) begin // [RL17]
            fast_wake_d = wr_data[BIT_FAST_WAKE]; // [RL1]
            stop_permit_d = wr_data[BIT_STOP_PERMIT]; // [RL3]
            reset_pin_d = wr_data[BIT_RESET_PIN];
            lock_d = 1'b1; // [RL17]
          end
        end
        ADDR_ROUTING: begin
          routing_d = wr_data[7:0] & ROUTING_STORE_MASK; // [RL5]
          sync_d = wr_data[BIT_PWM_SYNC]; // [RL8]
        end
        ADDR_DELAY_MODULO: modulo_d = wr_data[7:0];
        default: sync_d = 1'b0;
      endcase
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rd_state_q)
      RD_IDLE: begin
        if (arvalid && arready_q) begin
          rd_state_d = RD_RESP;
          rresp_d = addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
          case (16'(araddr))
            ADDR_PIN_POWER: rdata_d = {29'h0000_0000, reset_pin_q,
                                       fast_wake_q, stop_permit_q};
            ADDR_ROUTING: rdata_d = {24'h00_0000, routing_q};
            ADDR_DELAY_STATUS: rdata_d = {24'h00_0000, delay_active,
                                          7'h00};
            ADDR_DELAY_MODULO: rdata_d = {24'h00_0000, modulo_q};
            default: rdata_d = 32'h0000_0000;
          endcase
        end
      end
      RD_RESP: begin
        if (rready) begin
          rd_state_d = RD_IDLE;
        end
      end
      default: rd_state_d = RD_IDLE;
    endcase
    arready_d = (rd_state_d == RD_IDLE);
    rvalid_d = (rd_state_d == RD_RESP);
  end

  logic [3:0] src_level, src_rise;
  logic t2_rise, delay_start;
  route_out_s route_d, route_q;
  logic enter_stop_d, enter_stop_q, illegal_d, illegal_q;
  logic ext_reset_d, ext_reset_q;

  assign src_level = {route_i.t2_match_trig, route_i.t2_init_trig,
                      route_i.modulo_overflow, route_i.rtc_overflow};

  edge_rise #(
    .WIDTH(4)
  ) u_edge (
    .aclk(aclk),
    .aresetn(aresetn && por_n),
    .level(src_level),
    .rise(src_rise)
  );

  trigger_delay #(
    .CNT_W(DELAY_W)
  ) u_delay (
    .aclk(aclk),
    .aresetn(aresetn && por_n),
    .start(delay_start),
    .modulo(modulo_q[DELAY_W-1:0]),
    .active(delay_active),
    .done(delay_done)
  );

  // Routing is registered so every output leaves a flip-flop; it adds
  // one bus cycle of latency to each path.
  always_comb begin
    t2_rise = src_rise[routing_q[1:0]];
    delay_start = routing_q[1] && t2_rise; // [RL16]
    route_d.serial_transmit_out = routing_q[BIT_TX_MOD] ?
      (route_i.tx_data & route_i.timer_zero_ch0) : route_i.tx_data; // [RL7]
    route_d.rx_to_receiver = routing_q[BIT_RX_FILTER] ?
      route_i.comparator_out : route_i.serial_receive_in; // [RL9]
    route_d.timer_zero_ch1 = routing_q[BIT_RX_CAPTURE] &
      route_i.serial_receive_in; // [RL10]
    route_d.timer_one_ch0 = routing_q[BIT_CMP_CAPTURE] &
      route_i.comparator_out; // [RL11]
    route_d.timer_one_ch1 = routing_q[BIT_OVF_CAPTURE] &
      route_i.rtc_overflow; // [RL12]
    route_d.pwm_sync_trigger = sync_d; // [RL8]
    route_d.converter_trigger = routing_q[1] ? delay_done :
      t2_rise; // [RL13]
    enter_stop_d = stop_request && stop_permit_q; // [RL3]
    illegal_d = stop_request && !stop_permit_q; // [RL4]
    ext_reset_d = reset_pin_q && !port_a_pin_five; // [RL15]
  end

  // Bus, register and routing state.
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n) begin
      wr_state_q <= WR_IDLE;
      rd_state_q <= RD_IDLE;
      aw_lat_q <= '0;
      w_lat_q <= 32'h0000_0000;
      s_lat_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      fast_wake_q <= 1'b0;
      stop_permit_q <= 1'b0; // [RL3]
      lock_q <= 1'b0; // [RL17]
      routing_q <= ROUTING_RESET;
      modulo_q <= MODULO_RESET;
      route_q <= '0;
      enter_stop_q <= 1'b0;
      illegal_q <= 1'b0;
      ext_reset_q <= 1'b0;
    end else begin
      wr_state_q <= wr_state_d;
      rd_state_q <= rd_state_d;
      aw_lat_q <= aw_lat_d;
      w_lat_q <= w_lat_d;
      s_lat_q <= s_lat_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      fast_wake_q <= fast_wake_d;
      stop_permit_q <= stop_permit_d;
      lock_q <= lock_d;
      routing_q <= routing_d;
      modulo_q <= modulo_d;
      route_q <= route_d;
      enter_stop_q <= enter_stop_d;
      illegal_q <= illegal_d;
      ext_reset_q <= ext_reset_d;
    end
  end

  // The reset pin choice survives every reset except power-on.
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      reset_pin_q <= 1'b0;
    end else begin
      reset_pin_q <= reset_pin_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign route_o = route_q;
  assign enter_stop = enter_stop_q;
  assign illegal_opcode_reset = illegal_q;
  assign wake_without_isr = fast_wake_q; // [RL1]
  assign pin_reset_mode = reset_pin_q; // [RL15]
  assign external_reset = ext_reset_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);

  logic wr_pp, wr_rt;
  assign wr_pp = wr_do && wr_strb[0] && 16'(wr_addr) == ADDR_PIN_POWER;
  assign wr_rt = wr_do && wr_strb[0] && 16'(wr_addr) == ADDR_ROUTING;

  property p_stop_denied;
    stop_request && !stop_permit_q |=> illegal_q && !enter_stop_q;
  endproperty
  a_stop_denied: assert property (p_stop_denied) // [RL4]
    else $error("stop while not permitted gave no illegal reset");

  property p_stop_after_reset;
    $past(!aresetn) |-> !stop_permit_q && !lock_q;
  endproperty
  a_stop_after_reset: assert property (p_stop_after_reset) // [RL3]
    else $error("stop permit not cleared by reset");

  property p_write_once;
    wr_pp && lock_q |=> $stable(fast_wake_q) && $stable(stop_permit_q);
  endproperty
  a_write_once: assert property (p_write_once) // [RL17]
    else $error("locked control changed on a later write");

  property p_fast_wake;
    wr_pp && !lock_q |=> wake_without_isr == $past(wr_data[BIT_FAST_WAKE]);
  endproperty
  a_fast_wake: assert property (p_fast_wake) // [RL1]
    else $error("fast wake did not take the first write");

  property p_routing_free;
    wr_rt |=> routing_q == ($past(wr_data[7:0]) & ROUTING_STORE_MASK);
  endproperty
  a_routing_free: assert property (p_routing_free) // [RL5]
    else $error("routing register write lost");

  property p_sync_pulse;
    wr_rt && wr_data[BIT_PWM_SYNC] |=> route_o.pwm_sync_trigger
      ##1 !route_o.pwm_sync_trigger;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) // [RL8]
    else $error("sync trigger not a single pulse");

  property p_tx_mod;
    routing_q[BIT_TX_MOD] |=> route_o.serial_transmit_out ==
      ($past(route_i.tx_data) & $past(route_i.timer_zero_ch0));
  endproperty
  a_tx_mod: assert property (p_tx_mod) // [RL7]
    else $error("transmit modulation wrong");

  property p_rx_paths;
    1'b1 |=> route_o.timer_zero_ch1 == ($past(routing_q[BIT_RX_CAPTURE])
      & $past(route_i.serial_receive_in));
  endproperty
  a_rx_paths: assert property (p_rx_paths) // [RL10]
    else $error("receive capture route wrong");

  property p_ovf_capture;
    !routing_q[BIT_OVF_CAPTURE] |=> !route_o.timer_one_ch1;
  endproperty
  a_ovf_capture: assert property (p_ovf_capture) // [RL12]
    else $error("overflow reached capture while disabled");

  property p_direct_trigger;
    !routing_q[1] && src_rise[routing_q[1:0]] |=> route_o.converter_trigger;
  endproperty
  a_direct_trigger: assert property (p_direct_trigger) // [RL13]
    else $error("selected source edge gave no converter trigger");

  property p_pin_reset;
    reset_pin_q && !port_a_pin_five |=> external_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) // [RL15]
    else $error("pin reset not raised");

  c_write: cover property (wr_do ##[1:4] bvalid_q && bready);
  c_read: cover property (rvalid_q && rready);
  c_delayed: cover property (delay_start ##[1:300] route_o.converter_trigger);
  c_illegal: cover property (illegal_q);

endmodule : system_option_routing_regs
`default_nettype wire

// ===== src/trigger_delay.sv
`timescale 1ns/100ps
`default_nettype none
module trigger_delay
  import sys_opt_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic start, // One-cycle trigger that starts the delay.
  input wire logic [CNT_W-1:0] modulo, // Terminal count, 0 to 255.
  output logic active, // Counter is ticking.
  output logic done // One-cycle pulse when the count meets the modulo.
);

  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] count_q;
  logic active_d;
  logic active_q;

  // One-shot: a trigger while ticking is ignored rather than restarting.
  always_comb begin
    count_d = count_q;
    active_d = active_q;
    done = active_q && (count_q == modulo); // [RL16]
    if (active_q) begin
      if (done) begin
        active_d = 1'b0;
      end else begin
        count_d = count_q + 1'b1; // [RL16]
      end
    end else if (start) begin
      active_d = 1'b1;
      count_d = '0;
    end
  end

  assign active = active_q;

  // Counter state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      active_q <= 1'b0;
    end else begin
      count_q <= count_d;
      active_q <= active_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_start_counts_from_zero;
    start && !active_q |=> active_q && count_q == '0;
  endproperty
  a_start_counts_from_zero: assert property (p_start_counts_from_zero) // [RL16]
    else $error("delay did not start from zero");

  property p_stop_at_modulo;
    done |=> !active_q;
  endproperty
  a_stop_at_modulo: assert property (p_stop_at_modulo) // [RL16]
    else $error("delay kept ticking past the modulo");

endmodule : trigger_delay
`default_nettype wire

// ===== tb/peri_model.sv
`timescale 1ns/100ps
`default_nettype none
module peri_model
  import sys_opt_pkg::*;
(
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // Reset, active low.
  input wire route_out_s route_o, // Routed signals.
  output logic [7:0] conv_count, // Conversions started.
  output logic [7:0] sync_count // Sync triggers taken.
);
  // Converter and timer two act once per one-cycle start they see.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_count <= 8'h00;
      sync_count <= 8'h00;
    end else begin
      conv_count <= conv_count + {7'h00, route_o.converter_trigger};
      sync_count <= sync_count + {7'h00, route_o.pwm_sync_trigger};
    end
  end
endmodule : peri_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sys_opt_pkg::*;
  typedef struct packed {
    logic [7:0] rg;
    logic [7:0] ri;
    logic [4:0] ro;
  } row_s;
  row_s rows [6] = '{'{8'h00, 8'hFF, 5'h18}, '{8'h80, 8'hBF, 5'h08},
    '{8'h80, 8'hFF, 5'h18}, '{8'h3C, 8'h28, 5'h05},
    '{8'h3C, 8'h10, 5'h0A}, '{8'h1C, 8'h30, 5'h0E}};
  logic aclk, aresetn, por_n, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp, st;
  route_in_s route_i;
  route_out_s route_o;
  logic stop_request, enter_stop, illegal_opcode_reset, wake_without_isr;
  logic port_a_pin_five, pin_reset_mode, external_reset;
  logic [7:0] conv_count, sync_count, c0, m;
  int fail_count, cmp_count;
  int cyc = 1;

  system_option_routing_regs dut (.aclk(aclk), .aresetn(aresetn),
    .por_n(por_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .route_i(route_i),
    .route_o(route_o), .stop_request(stop_request),
    .enter_stop(enter_stop), .illegal_opcode_reset(illegal_opcode_reset),
    .wake_without_isr(wake_without_isr),
    .port_a_pin_five(port_a_pin_five), .pin_reset_mode(pin_reset_mode),
    .external_reset(external_reset));
  peri_model far_end (.aclk(aclk), .aresetn(aresetn), .route_o(route_o),
    .conv_count(conv_count), .sync_count(sync_count));

  // Free-running 10 MHz bus clock.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // A hung handshake must not stall the run forever.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // Both write channels are offered together and dropped once taken.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    {awvalid, wvalid} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    resp = bresp;
    if (n >= 50) fail_count++;
  endtask : wr

  task automatic rdr(input logic [15:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rd = rdata;
    resp = rresp;
    if (n >= 50) fail_count++;
  endtask : rdr

  // Stop pulse; the answer is sampled one edge later.
  task automatic stp();
    stop_request <= 1'b1;
    @(posedge aclk);
    stop_request <= 1'b0;
    @(posedge aclk);
    st = {enter_stop, illegal_opcode_reset};
  endtask : stp

  // Main sequence: table of routes first, then the awkward cases.
  initial begin
    // Both answer readies stay high, so every response is taken at once.
    {aresetn, por_n, awvalid, wvalid, bready, arvalid, rready} = 7'h05;
    {awaddr, araddr, wdata} = 64'h0000_0000_0000_0000;
    wstrb = 4'h1;
    route_i = 8'h00;
    {stop_request, port_a_pin_five} = 2'b01; // The reset pin idles high.
    {fail_count, cmp_count} = 64'h0000_0000_0000_0000;
    repeat (12) @(posedge aclk);
    {aresetn, por_n} <= 2'b11;
    tick(2);
    rdr(ADDR_PIN_POWER);
    chk("pin power reset", 32'h0000_0000, rd);
    wr(ADDR_ROUTING, 8'h00);
    foreach (rows[i]) begin
      wr(ADDR_ROUTING, rows[i].rg);
      route_i <= rows[i].ri;
      tick(3);
      chk("tx rx", 32'(rows[i].ro[4:3]), 32'(route_o[6:5]));
      chk("rx capture", 32'(rows[i].ro[2]), 32'(route_o[4]));
      chk("cmp capture", 32'(rows[i].ro[1]), 32'(route_o[3]));
      chk("ovf capture", 32'(rows[i].ro[0]), 32'(route_o[2]));
      rdr(ADDR_ROUTING);
      chk("routing reg", 32'(rows[i].rg & 8'hBF), rd);
    end
    $display("test routing done");
    wr(ADDR_DELAY_MODULO, 8'h03);
    for (int s = 0; s < 4; s++) begin
      m = 8'h08 >> s;
      wr(ADDR_ROUTING, {6'h00, s[1:0]});
      route_i <= 8'h00;
      tick(3);
      c0 = conv_count;
      route_i <= ~m;
      tick(12);
      route_i <= 8'hFF;
      tick(12);
      chk("conversions", 32'(c0 + 8'h01), 32'(conv_count));
    end
    $display("test trigger done");
    c0 = sync_count;
    wr(ADDR_ROUTING, 8'h40);
    tick(2);
    chk("sync", 32'(c0 + 8'h01), 32'(sync_count));
    rdr(ADDR_ROUTING);
    chk("sync bit", 32'h0000_0000, rd);
    wr(ADDR_DELAY_MODULO, 8'h14);
    wr(ADDR_ROUTING, 8'h02);
    route_i <= 8'h00;
    tick(3);
    route_i <= 8'h02;
    // The counter starts at the edge that sees the rise, so the status
    // read is launched one edge later or it would catch the idle state.
    tick(1);
    rdr(ADDR_DELAY_STATUS);
    chk("delay busy", 32'h0000_0080, rd);
    tick(30);
    rdr(ADDR_DELAY_STATUS);
    chk("delay idle", 32'h0000_0000, rd);
    // A write with its low strobe clear is answered but changes nothing.
    wstrb <= 4'h0;
    wr(ADDR_DELAY_MODULO, 8'hAA);
    wstrb <= 4'h1;
    chk("strobe off resp", 32'(RESP_OKAY), 32'(resp));
    rdr(ADDR_DELAY_MODULO);
    chk("strobe off", 32'h0000_0014, rd);
    $display("test delay done");
    stp();
    chk("stop refused", 32'h0000_0001, 32'(st));
    wr(ADDR_PIN_POWER, 8'h07);
    tick(1);
    chk("fast wake", 32'h0000_0001, 32'(wake_without_isr));
    chk("pin mode", 32'h0000_0001, 32'(pin_reset_mode));
    chk("pin idle", 32'h0000_0000, 32'(external_reset));
    port_a_pin_five <= 1'b0;
    tick(2);
    chk("pin reset", 32'h0000_0001, 32'(external_reset));
    port_a_pin_five <= 1'b1;
    wr(ADDR_PIN_POWER, 8'h00);
    rdr(ADDR_PIN_POWER);
    chk("write once", 32'h0000_0007, rd);
    // Stop permit is now set, so this stop is taken without an illegal reset.
    stp();
    chk("stop taken", 32'h0000_0002, 32'(st));
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    rdr(ADDR_PIN_POWER);
    chk("after reset", 32'h0000_0004, rd);
    stp();
    chk("stop refused again", 32'h0000_0001, 32'(st));
    $display("test power done");
    rdr(16'h0000);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0000_0000, rd);
    wr(16'h0000, 8'hFF);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(resp));
    $display("test unmapped done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
